/* design/sxp_defines.svh */
// Offsets, field positions, reset values and the contract list for the paged register bank
//
// Contract
// RQ1: Page zero sends 16-30 to main space
// RQ2: Page one sends 16-30 to extended page
// RQ3: GPIO page code redirects 0-30 to GPIO
// RQ4: Addresses 0-15 unaffected by extended page
// RQ5: Media control only reachable on extended page
// RQ6: Bits 15:14 transmit remote fault, reset 00
// RQ7: Bits 13:12 show partner remote fault
// RQ8: Bit 11 enables parallel detect, reset 0
// RQ9: Bit 10 reports media signal detect
// RQ10: Sticky bit 9 permits gigabit fiber link
// RQ11: Sticky bit 8 permits 100M fiber link
// RQ12: Bit 7 partner restart request, clear-on-read
// RQ13: Bit 6 100M far-end fault, clear-on-read
// RQ14: Bits 9/8 enable media/MAC equalization
// RQ15: Sticky swing fields 7:5, 4:2, default 100
// RQ16: Bit 15 packet since last read
// RQ17: Bits 13:0 count good-CRC packets
// RQ18: Good-CRC count wraps, never saturates
// RQ19: Reading count clears it to zero
// RQ20: Sticky fields survive software reset only
// RQ21: Bits 1/0 disable MAC/media hysteresis
`ifndef SXP_DEFINES_SVH
`define SXP_DEFINES_SVH

`define SXP_ADDR_MEDIA      5'h10
`define SXP_ADDR_TUNING     5'h11
`define SXP_ADDR_CRC        5'h12
`define SXP_ADDR_PAGE       5'h1F
`define SXP_ADDR_EXT_LO     5'h10

`define SXP_PAGE_MAIN       16'h0000
`define SXP_PAGE_EXT        16'h0001
`define SXP_PAGE_GPIO       16'h0010

`define SXP_MEDIA_TXRF_HI   15
`define SXP_MEDIA_TXRF_LO   14
`define SXP_MEDIA_LPRF_HI   13
`define SXP_MEDIA_LPRF_LO   12
`define SXP_MEDIA_PDET      11
`define SXP_MEDIA_SIGDET    10
`define SXP_MEDIA_ALLOW_1G  9
`define SXP_MEDIA_ALLOW_100 8
`define SXP_MEDIA_RESTART   7
`define SXP_MEDIA_FEF       6

`define SXP_TUNE_MEDIA_EQ   9
`define SXP_TUNE_MAC_EQ     8
`define SXP_TUNE_MSW_HI     7
`define SXP_TUNE_MSW_LO     5
`define SXP_TUNE_CSW_HI     4
`define SXP_TUNE_CSW_LO     2
`define SXP_TUNE_MAC_HYS    1
`define SXP_TUNE_MEDIA_HYS  0

`define SXP_CRC_SEEN        15
`define SXP_CRC_CNT_W       14

`define SXP_RST_SWING       3'h4
`define SXP_RST_ALLOW       1'h1

`endif

/* design/sxp_pkg.sv */
// Types shared by the paged register bank and its users
package sxp_pkg;

   typedef enum logic [1:0] {
      SXP_SPACE_MAIN,
      SXP_SPACE_EXT,
      SXP_SPACE_GPIO,
      SXP_SPACE_NONE
   } sxp_space_e;

   // Register port request from the management host
   typedef struct packed {
      logic [4:0]  addr;
      logic [15:0] wdata;
      logic        wr;
      logic        rd;
   } sxp_req_s;

   // Redirected access toward main or GPIO space
   typedef struct packed {
      logic [4:0]  addr;
      logic [15:0] wdata;
      logic        wr;
      logic        rd;
   } sxp_fwd_s;

   // Settings driven into the SerDes
   typedef struct packed {
      logic [1:0] tx_remote_fault;
      logic       parallel_detect;
      logic       allow_1g;
      logic       allow_100;
      logic       media_eq;
      logic       mac_eq;
      logic [2:0] media_swing;
      logic [2:0] mac_swing;
      logic       mac_hys_dis;
      logic       media_hys_dis;
   } sxp_cfg_s;

   // Events and levels from the SerDes side
   typedef struct packed {
      logic [1:0] link_partner_remote_fault;
      logic       signal_detect;
      logic       link_partner_restart;
      logic       far_end_fault;
      logic       good_crc_packet;
   } sxp_stat_s;

endpackage : sxp_pkg

/* design/sxp_page_regs.sv */
// Paged management register bank: page select, SerDes control and good-CRC counter
`timescale 1ns/10ps
`include "sxp_defines.svh"

module sxp_page_regs #(
   parameter int CNT_W = `SXP_CRC_CNT_W
) (
   // Clock, reset, enable
   input  wire logic                clock,
   input  wire logic                resetn,
   input  wire logic                soft_resetn,
   input  wire logic                clk_en,
   // Register port
   input  wire sxp_pkg::sxp_req_s   req,
   output logic [15:0]              rdata,
   // Redirected access toward main and GPIO spaces
   output sxp_pkg::sxp_fwd_s        main_fwd,
   output sxp_pkg::sxp_fwd_s        gpio_fwd,
   input  wire logic [15:0]         main_rdata,
   input  wire logic [15:0]         gpio_rdata,
   // SerDes side
   input  wire logic [1:0]          serdes_lprf_pin,
   input  wire logic                serdes_sigdet_pin,
   input  wire logic                link_partner_restart,
   input  wire logic                far_end_fault,
   input  wire logic                good_crc_packet,
   output sxp_pkg::sxp_cfg_s        cfg
);

   ////////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers for levels from the analog side

   logic [2:0] lprf0_ff;
   logic [2:0] lprf1_ff;
   logic [2:0] sigdet_ff;
   logic [1:0] lprf_ff;
   logic       sigdet_ok_ff;

   always_ff @(posedge clock)
   begin
      if (!resetn)
      begin
         lprf0_ff  <= 3'h0;
         lprf1_ff  <= 3'h0;
         sigdet_ff <= 3'h0;
      end
      else if (clk_en)
      begin
         lprf0_ff  <= {lprf0_ff[1:0], serdes_lprf_pin[0]};
         lprf1_ff  <= {lprf1_ff[1:0], serdes_lprf_pin[1]};
         sigdet_ff <= {sigdet_ff[1:0], serdes_sigdet_pin};
      end
   end

   // A change counts only once stages two and three agree
   wire lprf0_agree  = lprf0_ff[1] == lprf0_ff[2];
   wire lprf1_agree  = lprf1_ff[1] == lprf1_ff[2];
   wire sigdet_agree = sigdet_ff[1] == sigdet_ff[2];

   always_ff @(posedge clock)
   begin
      if (!resetn)
      begin
         lprf_ff      <= 2'h0;
         sigdet_ok_ff <= 1'h0;
      end
      else if (clk_en)
      begin
         if (lprf0_agree)
            lprf_ff[0] <= lprf0_ff[2];     // see RQ7
         if (lprf1_agree)
            lprf_ff[1] <= lprf1_ff[2];     // see RQ7
         if (sigdet_agree)
            sigdet_ok_ff <= sigdet_ff[2];  // see RQ9
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Address decode

   logic [15:0] page_ff;

   wire is_page   = req.addr == `SXP_ADDR_PAGE;
   wire upper     = req.addr >= `SXP_ADDR_EXT_LO;
   wire page_ext  = page_ff == `SXP_PAGE_EXT;
   wire page_gpio = page_ff == `SXP_PAGE_GPIO;

   // Page register itself never moves; GPIO page takes 0-30, extended page only 16-30
   wire sxp_pkg::sxp_space_e space =
      is_page                ? sxp_pkg::SXP_SPACE_NONE :
      page_gpio              ? sxp_pkg::SXP_SPACE_GPIO :  // see RQ3
      (page_ext && upper)    ? sxp_pkg::SXP_SPACE_EXT  :  // see RQ2 RQ4
                               sxp_pkg::SXP_SPACE_MAIN;   // see RQ1 RQ4

   wire in_ext   = space == sxp_pkg::SXP_SPACE_EXT;
   wire in_main  = space == sxp_pkg::SXP_SPACE_MAIN;
   wire in_gpio  = space == sxp_pkg::SXP_SPACE_GPIO;

   wire sel_media = in_ext && req.addr == `SXP_ADDR_MEDIA;   // see RQ5
   wire sel_tune  = in_ext && req.addr == `SXP_ADDR_TUNING;
   wire sel_crc   = in_ext && req.addr == `SXP_ADDR_CRC;

   wire wr_page  = req.wr && is_page;
   wire wr_media = req.wr && sel_media;
   wire wr_tune  = req.wr && sel_tune;
   wire rd_media = req.rd && sel_media;
   wire rd_crc   = req.rd && sel_crc;

   ////////////////////////////////////////////////////////////////////////////////
   // Page select and ordinary control bits (cleared by either reset)

   logic       any_rst;
   logic [1:0] txrf_ff;
   logic       pdet_ff;
   logic       media_eq_ff;
   logic       mac_eq_ff;
   logic       mac_hys_ff;
   logic       media_hys_ff;

   assign any_rst = !resetn || !soft_resetn;

   always_ff @(posedge clock)
   begin
      if (any_rst)
      begin
         page_ff      <= `SXP_PAGE_MAIN;
         txrf_ff      <= 2'h0;
         pdet_ff      <= 1'h0;
         media_eq_ff  <= 1'h0;
         mac_eq_ff    <= 1'h0;
         mac_hys_ff   <= 1'h0;
         media_hys_ff <= 1'h0;
      end
      else if (clk_en)
      begin
         if (wr_page)
            page_ff <= req.wdata;
         if (wr_media)
         begin
            txrf_ff <= req.wdata[`SXP_MEDIA_TXRF_HI:`SXP_MEDIA_TXRF_LO];  // see RQ6
            pdet_ff <= req.wdata[`SXP_MEDIA_PDET];                        // see RQ8
         end
         if (wr_tune)
         begin
            media_eq_ff  <= req.wdata[`SXP_TUNE_MEDIA_EQ];   // see RQ14
            mac_eq_ff    <= req.wdata[`SXP_TUNE_MAC_EQ];     // see RQ14
            mac_hys_ff   <= req.wdata[`SXP_TUNE_MAC_HYS];    // see RQ21
            media_hys_ff <= req.wdata[`SXP_TUNE_MEDIA_HYS];  // see RQ21
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Sticky bits: only the hardware reset restores them

   logic       allow_1g_ff;
   logic       allow_100_ff;
   logic [2:0] mswing_ff;
   logic [2:0] cswing_ff;

   always_ff @(posedge clock)
   begin
      if (!resetn)                                        // see RQ20
      begin
         allow_1g_ff  <= `SXP_RST_ALLOW;
         allow_100_ff <= `SXP_RST_ALLOW;
         mswing_ff    <= `SXP_RST_SWING;
         cswing_ff    <= `SXP_RST_SWING;
      end
      else if (clk_en)
      begin
         if (wr_media)
         begin
            allow_1g_ff  <= req.wdata[`SXP_MEDIA_ALLOW_1G];   // see RQ10
            allow_100_ff <= req.wdata[`SXP_MEDIA_ALLOW_100];  // see RQ11
         end
         // Reserved codes are stored as written; the analog side clamps them
         if (wr_tune)
         begin
            mswing_ff <= req.wdata[`SXP_TUNE_MSW_HI:`SXP_TUNE_MSW_LO];  // see RQ15
            cswing_ff <= req.wdata[`SXP_TUNE_CSW_HI:`SXP_TUNE_CSW_LO];  // see RQ15
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Clear-on-read events; an event in the read cycle survives the clear

   logic             restart_ff;
   logic             fef_ff;
   logic             seen_ff;
   logic [CNT_W-1:0] cnt_ff;

   wire [CNT_W-1:0] cnt_inc = cnt_ff + CNT_W'(1);   // see RQ18
   wire [CNT_W-1:0] nxt_cnt = rd_crc ? (good_crc_packet ? CNT_W'(1) : '0) :   // see RQ19
                              (good_crc_packet ? cnt_inc : cnt_ff);           // see RQ17

   always_ff @(posedge clock)
   begin
      if (any_rst)
      begin
         restart_ff <= 1'h0;
         fef_ff     <= 1'h0;
         seen_ff    <= 1'h0;
         cnt_ff     <= '0;
      end
      else if (clk_en)
      begin
         restart_ff <= link_partner_restart || (restart_ff && !rd_media);  // see RQ12
         fef_ff     <= far_end_fault || (fef_ff && !rd_media);             // see RQ13
         seen_ff    <= good_crc_packet || (seen_ff && !rd_crc);            // see RQ16
         cnt_ff     <= nxt_cnt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Read mux and forwarding

   wire [15:0] media_val = {txrf_ff, lprf_ff, pdet_ff, sigdet_ok_ff, allow_1g_ff,
                            allow_100_ff, restart_ff, fef_ff, 6'h00};
   wire [15:0] tune_val  = {6'h00, media_eq_ff, mac_eq_ff, mswing_ff, cswing_ff,
                            mac_hys_ff, media_hys_ff};
   // Count field is cut to its register width on purpose
   localparam int CRC_FIELD_W = `SXP_CRC_CNT_W;
   wire [CRC_FIELD_W-1:0] cnt_field = CRC_FIELD_W'(cnt_ff);
   wire [15:0] crc_val   = {seen_ff, 1'h0, cnt_field};

   // Unmapped extended offsets read zero
   wire [15:0] nxt_rdata = !req.rd  ? 16'h0000 :
                           is_page  ? page_ff :
                           in_gpio  ? gpio_rdata :
                           in_main  ? main_rdata :
                           sel_media ? media_val :
                           sel_tune ? tune_val :
                           sel_crc  ? crc_val : 16'h0000;

   wire sxp_pkg::sxp_fwd_s nxt_main = '{addr: req.addr, wdata: req.wdata,
                                        wr: req.wr && in_main, rd: req.rd && in_main};
   wire sxp_pkg::sxp_fwd_s nxt_gpio = '{addr: req.addr, wdata: req.wdata,
                                        wr: req.wr && in_gpio, rd: req.rd && in_gpio};

   sxp_pkg::sxp_fwd_s main_ff;
   sxp_pkg::sxp_fwd_s gpio_ff;
   sxp_pkg::sxp_cfg_s cfg_ff;
   logic [15:0]       rdata_ff;

   // Forwarded read data is sampled from the far space in the request cycle and shows on rdata one cycle later
   always_ff @(posedge clock)
   begin
      if (!resetn)
      begin
         rdata_ff <= 16'h0000;
         main_ff  <= '0;
         gpio_ff  <= '0;
         cfg_ff   <= '0;
      end
      else if (clk_en)
      begin
         rdata_ff <= nxt_rdata;
         main_ff  <= nxt_main;
         gpio_ff  <= nxt_gpio;
         cfg_ff   <= '{tx_remote_fault: txrf_ff, parallel_detect: pdet_ff,
                       allow_1g: allow_1g_ff, allow_100: allow_100_ff,
                       media_eq: media_eq_ff, mac_eq: mac_eq_ff,
                       media_swing: mswing_ff, mac_swing: cswing_ff,
                       mac_hys_dis: mac_hys_ff, media_hys_dis: media_hys_ff};
      end
   end

   assign rdata    = rdata_ff;
   assign main_fwd = main_ff;
   assign gpio_fwd = gpio_ff;
   assign cfg      = cfg_ff;

endmodule : sxp_page_regs

/* sim/sxp_page_regs_assertions.sv */
// Port checker for the paged register bank
`timescale 1ns/10ps
module sxp_page_regs_assertions (
   // Clock and resets
   input wire logic              clock,
   input wire logic              resetn,
   input wire logic              soft_resetn,
   input wire logic              clk_en,
   // Register port and forwarding
   input wire sxp_pkg::sxp_req_s req,
   input wire logic [15:0]       rdata,
   input wire sxp_pkg::sxp_fwd_s main_fwd,
   input wire sxp_pkg::sxp_fwd_s gpio_fwd,
   input wire logic [15:0]       main_rdata,
   input wire sxp_pkg::sxp_cfg_s cfg
);
   logic [15:0] pg_ff;
   // Page mirror, only to predict where an access must go
   always_ff @(posedge clock)
      if (!resetn || !soft_resetn) pg_ff <= 16'h0000;
      else if (clk_en && req.wr && req.addr == 5'h1F) pg_ff <= req.wdata;
   wire       ext = pg_ff == 16'h0001;
   wire       gp = pg_ff == 16'h0010;
   wire       acc = clk_en && (req.wr || req.rd);
   wire       loc = req.addr == 5'h1F;
   wire       hi = req.addr >= 5'h10;
   wire       to_main = acc && !loc && !gp && !(ext && hi);
   wire       to_gpio = acc && !loc && gp;
   wire       ext_wr = clk_en && req.wr && ext;
   wire [9:0] tw = req.wdata[9:0];
   wire [4:0] mw = {req.wdata[15:14], req.wdata[11], req.wdata[9:8]};
   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn || !soft_resetn);
   ////////////////////////////////////////
   a_main_route: assert property (to_main |=> main_fwd.addr == $past(req.addr)
      && main_fwd.rd == $past(req.rd) && !gpio_fwd.wr && !gpio_fwd.rd)
      else $error("access not sent to main space");
   a_gpio_route: assert property (to_gpio |=> gpio_fwd.addr == $past(req.addr)
      && (gpio_fwd.wr || gpio_fwd.rd) && !main_fwd.wr && !main_fwd.rd)
      else $error("access not sent to gpio space");
   a_ext_local: assert property (acc && ext && hi && !loc |=>
      !main_fwd.wr && !main_fwd.rd && !gpio_fwd.wr && !gpio_fwd.rd)
      else $error("extended access leaked out");
   a_main_data: assert property (to_main && req.rd |=> rdata == $past(main_rdata))
      else $error("main read data not returned");
   a_rdata_quiet: assert property (clk_en && !req.rd |=> rdata == 16'h0000)
      else $error("read data outside a read");
   a_fwd_cause: assert property (main_fwd.wr || gpio_fwd.wr |-> $past(req.wr))
      else $error("forwarded write without request");
   a_tune_cfg: assert property (ext_wr && req.addr == 5'h11 |=> ##1
      {cfg.media_eq, cfg.mac_eq, cfg.media_swing, cfg.mac_swing, cfg.mac_hys_dis,
       cfg.media_hys_dis} == $past(tw, 2))
      else $error("tuning settings not applied");
   a_media_cfg: assert property (ext_wr && req.addr == 5'h10 |=> ##1
      {cfg.tx_remote_fault, cfg.parallel_detect, cfg.allow_1g, cfg.allow_100} == $past(mw, 2))
      else $error("media settings not applied");
endmodule : sxp_page_regs_assertions

/* sim/tb_sxp_page_regs.sv */
// Self-checking bench for the paged register bank
`timescale 1ns/10ps
module tb_sxp_page_regs;
   logic              clock = 1'b0;
   logic              resetn = 1'b0;
   logic              soft_resetn = 1'b1;
   logic              clk_en = 1'b1;
   sxp_pkg::sxp_req_s req = '0;
   logic [15:0]       rdata;
   logic [1:0]        lprf = 2'b00;
   logic              sigdet = 1'b0;
   logic              restart = 1'b0;
   logic              fef = 1'b0;
   logic              pkt = 1'b0;
   sxp_pkg::sxp_cfg_s cfg;
   int                err_count = 0;
   int                samples_checked = 0;
   int                cyc = 0;
   // Main and GPIO spaces answer with fixed words
   sxp_page_regs uut (.clock(clock), .resetn(resetn), .soft_resetn(soft_resetn),
      .clk_en(clk_en), .req(req), .rdata(rdata), .main_fwd(), .gpio_fwd(),
      .main_rdata(16'hA5A5), .gpio_rdata(16'h5A5A), .serdes_lprf_pin(lprf),
      .serdes_sigdet_pin(sigdet), .link_partner_restart(restart),
      .far_end_fault(fef), .good_crc_packet(pkt), .cfg(cfg));
   initial forever #50 clock = ~clock;
   always @(posedge clock)
   begin
      cyc <= cyc + 1;
      if (cyc == 60000)
      begin
         err_count++;
         finish_test();
      end
   end
   ////////////////////////////////////////
   task automatic finish_test();
      $display("checked %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : finish_test
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      samples_checked++;
      if (g !== e)
      begin
         err_count++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge clock) req <= {a, d, 2'b10};
      @(posedge clock) req <= '0;
   endtask : wr
   task automatic rd(input logic [4:0] a, input logic [15:0] e, input string n);
      @(posedge clock) req <= {a, 16'h0000, 2'b01};
      @(posedge clock) req <= '0;
      @(negedge clock) chk(n, e, rdata);
   endtask : rd
   task automatic pk(input int n);
      repeat (n)
      begin
         @(posedge clock) pkt <= 1'b1;
         @(posedge clock) pkt <= 1'b0;
      end
   endtask : pk
   ////////////////////////////////////////
   task automatic t_defaults();
      rd(5'h1F, 16'h0000, "page");
      wr(5'h1F, 16'h0001);
      rd(5'h10, 16'h0300, "media");
      rd(5'h11, 16'h0090, "tuning");
      rd(5'h12, 16'h0000, "crc");
      $display("defaults done");
   endtask : t_defaults
   task automatic t_paging();
      wr(5'h1F, 16'h0000);
      rd(5'h10, 16'hA5A5, "main 16");
      wr(5'h1F, 16'h0001);
      rd(5'h05, 16'hA5A5, "main 5");
      rd(5'h13, 16'h0000, "unmapped");
      wr(5'h1F, 16'h0010);
      rd(5'h05, 16'h5A5A, "gpio 5");
      rd(5'h1E, 16'h5A5A, "gpio 30");
      rd(5'h1F, 16'h0010, "page gpio");
      wr(5'h1F, 16'h0002);
      rd(5'h11, 16'hA5A5, "odd page");
      wr(5'h1F, 16'h0001);
      $display("paging done");
   endtask : t_paging
   task automatic t_media();
      wr(5'h10, 16'hFFFF);
      lprf <= 2'b10;
      sigdet <= 1'b1;
      repeat (6) @(posedge clock);
      rd(5'h10, 16'hEF00, "media set");
      chk("txrf", 16'h0003, 16'(cfg.tx_remote_fault));
      wr(5'h10, 16'h00C0);
      rd(5'h10, 16'h2400, "media clr");
      chk("allow", 16'h0000, 16'({cfg.allow_1g, cfg.allow_100}));
      @(posedge clock) restart <= 1'b1;
      fef <= 1'b1;
      @(posedge clock) restart <= 1'b0;
      fef <= 1'b0;
      rd(5'h10, 16'h24C0, "events");
      rd(5'h10, 16'h2400, "events gone");
      $display("media done");
   endtask : t_media
   task automatic t_tuning();
      wr(5'h11, 16'hFFFF);
      rd(5'h11, 16'h03FF, "tune all");
      wr(5'h11, 16'h0357);
      rd(5'h11, 16'h0357, "tune mix");
      chk("mac swing", 16'h0005, 16'(cfg.mac_swing));
      $display("tuning done");
   endtask : t_tuning
   task automatic t_crc();
      pk(3);
      rd(5'h12, 16'h8003, "crc 3");
      rd(5'h12, 16'h0000, "crc clr");
      pk(16386);
      rd(5'h12, 16'h8002, "crc wrap");
      // Packet in the read cycle must survive the clear
      pk(2);
      @(posedge clock)
      begin
         req <= {5'h12, 16'h0000, 2'b01};
         pkt <= 1'b1;
      end
      @(posedge clock)
      begin
         req <= '0;
         pkt <= 1'b0;
      end
      @(negedge clock) chk("crc race", 16'h8002, rdata);
      rd(5'h12, 16'h8001, "crc after race");
      $display("crc done");
   endtask : t_crc
   task automatic t_soft();
      @(posedge clock) soft_resetn <= 1'b0;
      @(posedge clock) soft_resetn <= 1'b1;
      rd(5'h1F, 16'h0000, "page soft");
      wr(5'h1F, 16'h0001);
      rd(5'h11, 16'h0054, "tune soft");
      rd(5'h10, 16'h2400, "media soft");
      $display("soft reset done");
   endtask : t_soft
   // A write while the enable is low must leave the bank untouched
   task automatic t_freeze();
      @(posedge clock) clk_en <= 1'b0;
      wr(5'h11, 16'h0000);
      clk_en <= 1'b1;
      rd(5'h11, 16'h0054, "tune frozen");
      $display("freeze done");
   endtask : t_freeze
   initial
   begin
      repeat (8) @(posedge clock);
      resetn <= 1'b1;
      t_defaults();
      t_paging();
      t_media();
      t_tuning();
      t_crc();
      t_soft();
      t_freeze();
      finish_test();
   end
endmodule : tb_sxp_page_regs
bind sxp_page_regs sxp_page_regs_assertions u_chk (.clock(clock), .resetn(resetn),
   .soft_resetn(soft_resetn), .clk_en(clk_en), .req(req), .rdata(rdata),
   .main_fwd(main_fwd), .gpio_fwd(gpio_fwd), .main_rdata(main_rdata), .cfg(cfg));
